// ===== shared/lane_word_pkg.sv
package lane_word_pkg;

  // Symbol bytes, Dx.y packed as {y[2:0], x[4:0]}
  localparam logic [7:0] SYM_COMMA      = 8'hFC; // K28.7
  localparam logic [7:0] SYM_INIT_COMMA = 8'hBC; // K28.5
  localparam logic [7:0] SYM_IDENT      = 8'hCE; // D14.6
  localparam logic [7:0] SYM_INV_IDENT  = 8'h31; // D17.1
  localparam logic [7:0] SYM_IDLE       = 8'hCF; // D15.6
  localparam logic [7:0] SYM_STAGE_ONE  = 8'h46; // D6.2
  localparam logic [7:0] SYM_STAGE_TWO  = 8'hA6; // D6.5
  localparam logic [7:0] SYM_INV_ONE    = 8'hB9; // D25.5
  localparam logic [7:0] SYM_INV_TWO    = 8'h59; // D25.2
  localparam logic [7:0] SYM_CAPABILITY = 8'h38; // D24.1
  localparam logic [7:0] SYM_STANDBY    = 8'h7E; // D30.3
  localparam logic [7:0] SYM_LOST       = 8'h64; // D4.3

  // Control-symbol flags: only the first symbol is a K code
  localparam logic [3:0] LANE_WORD_K = 4'h1;

  // Field positions in capability and reason symbols
  localparam int CAP_FLUSH_BIT    = 0;
  localparam int CAP_START_BIT    = 1;
  localparam int CAP_SCRAMBLE_BIT = 2;
  localparam int LOST_CAUSE_BIT   = 0;

  // Words the decoder recognises, index order of the match vector
  localparam int NUM_PATTERNS = 8;
  localparam int PAT_IDLE = 0;
  localparam int PAT_ONE  = 1;
  localparam int PAT_TWO  = 2;
  localparam int PAT_INV1 = 3;
  localparam int PAT_INV2 = 4;
  localparam int PAT_CAP  = 5;
  localparam int PAT_STBY = 6;
  localparam int PAT_LOST = 7;
  localparam logic [NUM_PATTERNS-1:0][31:0] PATTERNS = {
    {8'h00, SYM_LOST, SYM_IDENT, SYM_COMMA},
    {SYM_STANDBY, SYM_STANDBY, SYM_IDENT, SYM_COMMA},
    {8'h00, SYM_CAPABILITY, SYM_IDENT, SYM_INIT_COMMA},
    {SYM_INV_TWO, SYM_INV_TWO, SYM_INV_IDENT, SYM_INIT_COMMA},
    {SYM_INV_ONE, SYM_INV_ONE, SYM_INV_IDENT, SYM_INIT_COMMA},
    {SYM_STAGE_TWO, SYM_STAGE_TWO, SYM_IDENT, SYM_INIT_COMMA},
    {SYM_STAGE_ONE, SYM_STAGE_ONE, SYM_IDENT, SYM_INIT_COMMA},
    {SYM_IDLE, SYM_IDLE, SYM_IDENT, SYM_COMMA}};
  localparam logic [31:0] MASK_FULL = 32'hFFFFFFFF;
  localparam logic [31:0] MASK_HEAD = 32'h00FFFFFF;
  localparam logic [NUM_PATTERNS-1:0][31:0] MASKS = {
    MASK_HEAD, MASK_FULL, MASK_HEAD, MASK_FULL,
    MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL};

  // Transmit commands from the lane state machine
  localparam logic [2:0] CMD_DATA    = 3'h0;
  localparam logic [2:0] CMD_ONE     = 3'h1;
  localparam logic [2:0] CMD_TWO     = 3'h2;
  localparam logic [2:0] CMD_CAP     = 3'h3;
  localparam logic [2:0] CMD_STANDBY = 3'h4;

  // Standby announcement length in words before the driver goes off
  localparam logic [3:0] STANDBY_REPEAT = 4'h4;

  // Register map (byte addresses) and reset values
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_ERRCNT  = 8'h08;
  localparam logic [2:0]  CTRL_RESET  = 3'h0;
  localparam logic [31:0] WORD_RESET  = 32'h00000000;

  typedef enum logic [2:0] {
    TX_RUN   = 3'b001,
    TX_STBY  = 3'b010,
    TX_OFF   = 3'b100
  } tx_state_e;

endpackage : lane_word_pkg

// ===== logic/lane_word_match.sv
`timescale 1ns/10ps
// Compares one received word with a fixed lane word under a mask
module lane_word_match #(
  parameter logic [31:0] PATTERN = 32'h00000000,
  parameter logic [31:0] MASK    = 32'hFFFFFFFF,
  parameter logic [3:0]  KFLAGS  = 4'h1
) (
  input  wire logic [31:0] word,
  input  wire logic [3:0]  k,
  output logic             hit
);

  // K flags must match exactly; masked bytes are free data
  assign hit = ((word & MASK) == PATTERN) && (k == KFLAGS);

endmodule : lane_word_match

// ===== logic/lane_control_word_codec.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module lane_control_word_codec
  import lane_word_pkg::*;
#(
  parameter int ERR_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Lane state machine and retry layer, transmit side
  input  wire logic [2:0]       tx_cmd,
  input  wire logic             tx_data_valid,
  input  wire logic [31:0]      tx_data,
  input  wire logic [3:0]       tx_data_k,
  output logic                  tx_ready,
  input  wire logic             sig_absent,
  input  wire logic             error_burst,
  output logic [31:0]           tx_word,
  output logic [3:0]            tx_k,
  output logic                  driver_on,
  // Receive side
  input  wire logic             rx_valid,
  input  wire logic [31:0]      rx_word,
  input  wire logic [3:0]       rx_k,
  output logic                  rx_idle,
  output logic                  rx_stage_one,
  output logic                  rx_stage_two,
  output logic                  rx_inv_one,
  output logic                  rx_inv_two,
  output logic                  rx_capability,
  output logic                  rx_standby,
  output logic                  rx_lost,
  output logic                  rx_error,
  output logic                  remote_flush,
  output logic [2:0]            peer_cap,
  output logic                  peer_lost_reason,
  output logic                  standby_heard
);

  ////////////////////////////////////////////////////////////////////////////
  // State record

  typedef struct packed {
    logic [31:0]      tx_word;
    logic [3:0]       tx_k;
    logic             tx_ready;
    logic             driver_on;
    tx_state_e        tx_state;
    logic [3:0]       rep_cnt;
    logic             rx_idle;
    logic             rx_stage_one;
    logic             rx_stage_two;
    logic             rx_inv_one;
    logic             rx_inv_two;
    logic             rx_capability;
    logic             rx_standby;
    logic             rx_lost;
    logic             rx_error;
    logic             remote_flush;
    logic [2:0]       peer_cap;
    logic             peer_lost_reason;
    logic             standby_heard;
    logic             inv_seen;
    logic [2:0]       ctrl;
    logic [ERR_W-1:0] err_cnt;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } state_s;

  state_s cur;
  state_s next_cur;

  ////////////////////////////////////////////////////////////////////////////
  // Receive word matchers

  logic [NUM_PATTERNS-1:0] hit;

  // One comparator per known lane word
  // inverted words matched
  for (genvar i = 0; i < NUM_PATTERNS; i++) begin : g_match
    lane_word_match #(
      .PATTERN (PATTERNS[i]),
      .MASK    (MASKS[i]),
      .KFLAGS  (LANE_WORD_K)
    ) u_match (
      .word (rx_word),
      .k    (rx_k),
      .hit  (hit[i])
    );
  end

  logic comma_led;
  logic lane_owned;
  logic unknown_word;

  // comma-led lane check
  // Other layers' words share the comma but not the identifier, so only
  // words naming the lane identifier (plain or inverted) are judged here.
  assign comma_led    = rx_k[0] && (rx_word[7:0] == SYM_COMMA || rx_word[7:0] == SYM_INIT_COMMA);
  assign lane_owned   = rx_word[15:8] == SYM_IDENT || rx_word[15:8] == SYM_INV_IDENT;
  assign unknown_word = rx_valid && comma_led && lane_owned && (hit == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit word selection

  logic       lost_wanted;
  logic       lost_reason;
  logic [7:0] cap_sym;
  logic [7:0] reason_sym;

  assign lost_wanted = (sig_absent || error_burst) && !cur.standby_heard;
  assign lost_reason = !sig_absent;
  assign cap_sym    = {5'h00, cur.ctrl};
  assign reason_sym = {7'h00, lost_reason};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic        apb_access;
  logic        apb_setup;
  logic [31:0] read_value;
  logic        addr_ok;

  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable && cur.pready;

  // Read mux for the setup cycle; data is held through the access phase
  always_comb begin
    read_value = WORD_RESET;
    addr_ok    = 1'b1;
    case (paddr)
      REG_CTRL:   read_value = {29'h0, cur.ctrl};
      REG_STATUS: read_value = {24'h0, cur.tx_state == TX_OFF, cur.inv_seen, cur.driver_on,
                                cur.peer_lost_reason, cur.peer_cap, cur.standby_heard};
      REG_ERRCNT: read_value = {{(32-ERR_W){1'b0}}, cur.err_cnt};
      default:    addr_ok    = 1'b0;
    endcase
  end

  always_comb begin
    next_cur = cur;

    //////////////////////////////////////////////////////////////////////////
    // APB: one wait-free access, answer in the first access cycle
    next_cur.pready  = apb_setup;
    next_cur.pslverr = apb_setup && !addr_ok;
    if (apb_setup) begin
      next_cur.prdata = pwrite ? WORD_RESET : read_value;
    end else if (apb_access) begin
      next_cur.prdata = WORD_RESET;
    end
    if (apb_access && pwrite && paddr == REG_CTRL) begin
      next_cur.ctrl = pwdata[2:0];
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmit path
    // comma in byte 0 of control words; retry layer words bring their own K flags
    next_cur.tx_k     = LANE_WORD_K;
    next_cur.tx_ready = 1'b0;
    next_cur.rep_cnt  = cur.rep_cnt;
    case (cur.tx_state)
      TX_RUN: begin
        next_cur.driver_on = 1'b1;
        if (tx_cmd == CMD_STANDBY) begin
          next_cur.tx_word  = {SYM_STANDBY, SYM_STANDBY, SYM_IDENT, SYM_COMMA};
          next_cur.rep_cnt  = STANDBY_REPEAT - 4'h1;
          next_cur.tx_state = TX_STBY;
        end else if (lost_wanted) begin
          next_cur.tx_word = {reason_sym, SYM_LOST, SYM_IDENT, SYM_COMMA};
        end else if (tx_cmd == CMD_ONE) begin
          next_cur.tx_word = {SYM_STAGE_ONE, SYM_STAGE_ONE, SYM_IDENT, SYM_INIT_COMMA};
        end else if (tx_cmd == CMD_TWO) begin
          next_cur.tx_word = {SYM_STAGE_TWO, SYM_STAGE_TWO, SYM_IDENT, SYM_INIT_COMMA};
        end else if (tx_cmd == CMD_CAP) begin
          next_cur.tx_word = {cap_sym, SYM_CAPABILITY, SYM_IDENT, SYM_INIT_COMMA};
        end else if (cur.tx_ready && tx_data_valid) begin
          // Retry layer word, taken while the offer stood
          next_cur.tx_word = tx_data;
          next_cur.tx_k    = tx_data_k;
        end else begin
          next_cur.tx_word = {SYM_IDLE, SYM_IDLE, SYM_IDENT, SYM_COMMA};
        end
        // Offer for the next edge; registered so the retry layer sees a flop
        next_cur.tx_ready = tx_cmd == CMD_DATA && !lost_wanted;
      end
      TX_STBY: begin
        next_cur.tx_word = {SYM_STANDBY, SYM_STANDBY, SYM_IDENT, SYM_COMMA};
        if (cur.rep_cnt == 4'h0) begin
          next_cur.tx_state  = TX_OFF;
          next_cur.driver_on = 1'b0;
        end else begin
          next_cur.rep_cnt = cur.rep_cnt - 4'h1;
        end
      end
      TX_OFF: begin
        // Driver off; idle pattern kept on the word so nothing random leaks
        next_cur.tx_word   = {SYM_IDLE, SYM_IDLE, SYM_IDENT, SYM_COMMA};
        next_cur.driver_on = 1'b0;
        if (tx_cmd != CMD_STANDBY) begin
          next_cur.tx_state  = TX_RUN;
          next_cur.driver_on = 1'b1;
        end
      end
      default: begin
        next_cur.tx_state  = TX_RUN;
        next_cur.driver_on = 1'b1;
        next_cur.tx_word   = {SYM_IDLE, SYM_IDLE, SYM_IDENT, SYM_COMMA};
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // Receive decode: one-cycle pulses, one cycle after the word
    next_cur.rx_idle       = rx_valid && hit[PAT_IDLE];
    next_cur.rx_stage_one  = rx_valid && hit[PAT_ONE];
    next_cur.rx_stage_two  = rx_valid && hit[PAT_TWO];
    next_cur.rx_inv_one    = rx_valid && hit[PAT_INV1];
    next_cur.rx_inv_two    = rx_valid && hit[PAT_INV2];
    next_cur.rx_capability = rx_valid && hit[PAT_CAP];
    next_cur.rx_standby    = rx_valid && hit[PAT_STBY];
    next_cur.rx_lost       = rx_valid && hit[PAT_LOST];
    next_cur.rx_error      = unknown_word;
    next_cur.remote_flush  = 1'b0;

    if (rx_valid && (hit[PAT_INV1] || hit[PAT_INV2])) begin
      next_cur.inv_seen = 1'b1;
    end else if (rx_valid && (hit[PAT_ONE] || hit[PAT_TWO])) begin
      next_cur.inv_seen = 1'b0;
    end

    if (rx_valid && hit[PAT_CAP]) begin
      next_cur.peer_cap     = rx_word[26:24];
      next_cur.remote_flush = rx_word[24 + CAP_FLUSH_BIT];
    end
    if (rx_valid && hit[PAT_LOST]) begin
      next_cur.peer_lost_reason = rx_word[24 + LOST_CAUSE_BIT];
    end

    // remember far end went to standby; a fresh handshake clears it
    if (rx_valid && hit[PAT_STBY]) begin
      next_cur.standby_heard = 1'b1;
    end else if (rx_valid &&
                 (hit[PAT_ONE] || hit[PAT_TWO] || hit[PAT_INV1] || hit[PAT_INV2])) begin
      next_cur.standby_heard = 1'b0;
    end

    // Error count: write clears, a same-cycle error still counts
    if (apb_access && pwrite && paddr == REG_ERRCNT) begin
      next_cur.err_cnt = unknown_word ? {{(ERR_W-1){1'b0}}, 1'b1} : '0;
    end else if (unknown_word && cur.err_cnt != '1) begin
      next_cur.err_cnt = cur.err_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Reset puts the transmitter on idle words with the driver on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur          <= '0;
      cur.tx_word  <= {SYM_IDLE, SYM_IDLE, SYM_IDENT, SYM_COMMA};
      cur.tx_k     <= LANE_WORD_K;
      cur.tx_state <= TX_RUN;
      cur.driver_on <= 1'b1;
      cur.ctrl     <= CTRL_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state record

  assign prdata           = cur.prdata;
  assign pready           = cur.pready;
  assign pslverr          = cur.pslverr;
  assign tx_ready         = cur.tx_ready;
  assign tx_word          = cur.tx_word;
  assign tx_k             = cur.tx_k;
  assign driver_on        = cur.driver_on;
  assign rx_idle          = cur.rx_idle;
  assign rx_stage_one     = cur.rx_stage_one;
  assign rx_stage_two     = cur.rx_stage_two;
  assign rx_inv_one       = cur.rx_inv_one;
  assign rx_inv_two       = cur.rx_inv_two;
  assign rx_capability    = cur.rx_capability;
  assign rx_standby       = cur.rx_standby;
  assign rx_lost          = cur.rx_lost;
  assign rx_error         = cur.rx_error;
  assign remote_flush     = cur.remote_flush;
  assign peer_cap         = cur.peer_cap;
  assign peer_lost_reason = cur.peer_lost_reason;
  assign standby_heard    = cur.standby_heard;

endmodule : lane_control_word_codec

// ===== testbench/lane_codec_monitor.sv
`timescale 1ns/10ps
// Port-level relations of the codec, one word clock
module lane_codec_monitor
  import lane_word_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [2:0]  tx_cmd,
  input wire logic        tx_data_valid,
  input wire logic        tx_ready,
  input wire logic        sig_absent,
  input wire logic        error_burst,
  input wire logic [31:0] tx_word,
  input wire logic        driver_on,
  input wire logic        rx_valid,
  input wire logic [31:0] rx_word,
  input wire logic [3:0]  rx_k,
  input wire logic        rx_inv_one,
  input wire logic        rx_capability,
  input wire logic        remote_flush,
  input wire logic        rx_error,
  input wire logic        standby_heard
);
  ////////////////////////////////////////
  logic run;
  logic quiet;
  logic lane_rx;
  // Outside a standby burst, so plain priority applies
  assign run     = driver_on && tx_word != 32'h7E7ECEFC;
  assign quiet   = !sig_absent && !error_burst;
  assign lane_rx = rx_valid && rx_k == LANE_WORD_K;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  idle_fill_a: assert property (
    run && tx_cmd == CMD_DATA && quiet && !(tx_ready && tx_data_valid)
    |=> tx_word == 32'hCFCFCEFC) else $error("idle word missing");
  stage_one_a: assert property (
    run && tx_cmd == CMD_ONE && quiet |=> tx_word == 32'h4646CEBC)
    else $error("stage one word wrong");
  cap_word_a: assert property (
    run && tx_cmd == CMD_CAP && quiet
    |=> tx_word[23:0] == 24'h38CEBC && tx_word[31:27] == 5'h00) else $error("capability wrong");
  lost_word_a: assert property (
    run && tx_cmd != CMD_STANDBY && !quiet && !standby_heard
    |=> tx_word == {7'h00, !$past(sig_absent), 24'h64CEFC}) else $error("lost word wrong");
  lost_mute_a: assert property (
    standby_heard |=> tx_word[23:0] != 24'h64CEFC) else $error("lost word not muted");
  no_inverse_a: assert property (
    !$past(tx_ready && tx_data_valid) |-> tx_word[15:0] != 16'h31BC)
    else $error("inverted word sent");
  standby_burst_a: assert property (
    run && tx_cmd == CMD_STANDBY |=> (tx_word == 32'h7E7ECEFC)[*4] ##1 !driver_on)
    else $error("standby burst wrong");
  rx_inverse_a: assert property (
    lane_rx && rx_word == 32'hB9B931BC |=> rx_inv_one) else $error("inverse not seen");
  rx_flush_a: assert property (
    lane_rx && rx_word[23:0] == 24'h38CEBC
    |=> rx_capability && remote_flush == $past(rx_word[24])) else $error("flush wrong");
  rx_error_a: assert property (
    lane_rx && rx_word[23:0] == 24'h00CEFC |=> rx_error) else $error("error not raised");
endmodule : lane_codec_monitor

bind lane_control_word_codec lane_codec_monitor lane_codec_monitor_i (
  .clk, .rst_n, .tx_cmd, .tx_data_valid, .tx_ready, .sig_absent, .error_burst, .tx_word,
  .driver_on, .rx_valid, .rx_word, .rx_k, .rx_inv_one, .rx_capability, .remote_flush,
  .rx_error, .standby_heard);

// ===== testbench/lane_peer_model.sv
`timescale 1ns/10ps
// Far lane endpoint: idles unless told to send one word or to go mute
module lane_peer_model
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        send,
  input wire logic [31:0] word,
  input wire logic [3:0]  k,
  input wire logic        mute,
  output logic            rx_valid,
  output logic [31:0]     rx_word,
  output logic [3:0]      rx_k
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_word  <= 32'h00000000;
      rx_k     <= 4'h0;
    end else if (mute) begin
      // Released line toggles, so a stale word never looks steady
      rx_valid <= 1'b0;
      rx_word  <= ~rx_word;
    end else begin
      rx_valid <= 1'b1;
      rx_word  <= send ? word : 32'hCFCFCEFC;
      rx_k     <= send ? k : 4'h1;
    end
  end
endmodule : lane_peer_model

// ===== testbench/lane_control_word_codec_bench.sv
`timescale 1ns/10ps
// Registers, transmit words and receive decoding of the codec
module lane_control_word_codec_bench
  import lane_word_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, tx_data = 32'h0, pw = 32'h0, prdata, tx_word, rx_word, r;
  logic [2:0]  tx_cmd = 3'h0, peer_cap;
  logic [3:0]  tx_data_k = 4'h0, pk = 4'h0, tx_k, rx_k;
  logic        tx_data_valid = 1'b0, sig_absent = 1'b0, error_burst = 1'b0;
  logic        send = 1'b0, mute = 1'b0, e, pready, pslverr, tx_ready, driver_on, rx_valid;
  logic        rx_idle, rx_stage_one, rx_stage_two, rx_inv_one, rx_inv_two;
  logic        rx_capability, rx_standby, rx_lost, rx_error, remote_flush;
  logic        peer_lost_reason, standby_heard;
  logic [9:0]  pulses;
  int          num_errors = 0, comparisons = 0;
  ////////////////////////////////////////
  always #2.5 clk = ~clk;
  // Receive pulses gathered into one vector, idle in bit 0
  assign pulses = {remote_flush, rx_error, rx_lost, rx_standby, rx_capability,
                   rx_inv_two, rx_inv_one, rx_stage_two, rx_stage_one, rx_idle};
  lane_control_word_codec lane_control_word_codec_i (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_cmd, .tx_data_valid, .tx_data, .tx_data_k, .tx_ready, .sig_absent, .error_burst,
    .tx_word, .tx_k, .driver_on, .rx_valid, .rx_word, .rx_k, .rx_idle, .rx_stage_one,
    .rx_stage_two, .rx_inv_one, .rx_inv_two, .rx_capability, .rx_standby, .rx_lost,
    .rx_error, .remote_flush, .peer_cap, .peer_lost_reason, .standby_heard);
  lane_peer_model lane_peer_model_i (
    .clk, .rst_n, .send, .word(pw), .k(pk), .mute, .rx_valid, .rx_word, .rx_k);
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Setup then access; waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic gather(output logic [9:0] acc);
    acc = 10'h000;
    repeat (4) begin
      tick(1);
      acc = acc | pulses;
    end
  endtask : gather
  task automatic peer_word(input logic [31:0] wd, input logic [3:0] kk, output logic [9:0] acc);
    @(posedge clk);
    send <= 1'b1;
    pw   <= wd;
    pk   <= kk;
    @(posedge clk);
    send <= 1'b0;
    gather(acc);
  endtask : peer_word
  ////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h00000000, r);
    apb(1'b1, REG_STATUS, 32'hFFFFFFFF);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status reset", 32'h00000020, r);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
  endtask : t_regs
  task automatic t_init(input logic [2:0] c);
    logic [31:0] exp [1:3];
    apb(1'b1, REG_CTRL, {29'h0, c});
    exp[1] = 32'h4646CEBC;
    exp[2] = 32'hA6A6CEBC;
    exp[3] = {5'h00, c, 24'h38CEBC};
    for (int i = 1; i <= 3; i++) begin
      @(posedge clk);
      tx_cmd <= 3'(i);
      tick(1);
      chk("init word", exp[i], tx_word);
      chk("init k", 32'h1, {28'h0, tx_k});
    end
    @(posedge clk);
    tx_cmd <= CMD_DATA;
  endtask : t_init
  task automatic t_data();
    @(posedge clk);
    tx_data       <= 32'h5A3C0F96;
    tx_data_k     <= 4'h2;
    tx_data_valid <= 1'b1;
    do begin
      @(posedge clk);
    end while (tx_ready !== 1'b1);
    tx_data_valid <= 1'b0;
    tick(0);
    chk("data word", 32'h5A3C0F96, tx_word);
    chk("data k", 32'h2, {28'h0, tx_k});
    tick(1);
    chk("idle word", 32'hCFCFCEFC, tx_word);
  endtask : t_data
  task automatic t_lost();
    logic [31:0] exp [3];
    exp = '{32'h0064CEFC, 32'h0164CEFC, 32'h0064CEFC};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      sig_absent  <= (i != 1);
      error_burst <= (i != 0);
      tick(1);
      chk("lost word", exp[i], tx_word);
    end
    @(posedge clk);
    sig_absent  <= 1'b0;
    error_burst <= 1'b0;
  endtask : t_lost
  task automatic t_rx();
    logic [31:0] w [11];
    logic [9:0]  p [11];
    logic [9:0]  acc;
    w = '{32'hCFCFCEFC, 32'h4646CEBC, 32'hA6A6CEBC, 32'hB9B931BC, 32'h595931BC, 32'h0538CEBC,
          32'hFA38CEBC, 32'hFF64CEFC, 32'h0000CEFC, 32'h0000CEFC, 32'h7E7ECEFC};
    p = '{10'h001, 10'h003, 10'h005, 10'h009, 10'h011, 10'h221,
          10'h021, 10'h081, 10'h101, 10'h001, 10'h041};
    // Word 9 lacks the K flag, so it must pass as another layer's word
    for (int i = 0; i < 11; i++) begin
      peer_word(w[i], (i == 9) ? 4'h0 : 4'h1, acc);
      chk("rx pulses", {22'h0, p[i]}, {22'h0, acc});
    end
    chk("peer cap", 32'h2, {29'h0, peer_cap});
    chk("lost reason", 32'h1, {31'h0, peer_lost_reason});
    apb(1'b0, REG_ERRCNT, 32'h0);
    chk("error count", 32'h1, r);
    apb(1'b1, REG_ERRCNT, 32'h0);
    apb(1'b0, REG_ERRCNT, 32'h0);
    chk("error cleared", 32'h0, r);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h00000075, r);
    @(posedge clk);
    sig_absent <= 1'b1;
    tick(2);
    chk("lost muted", 32'hCFCFCEFC, tx_word);
    @(posedge clk);
    mute <= 1'b1;
    tick(2);
    gather(acc);
    chk("muted rx", 32'h0, {22'h0, acc});
    @(posedge clk);
    mute       <= 1'b0;
    sig_absent <= 1'b0;
    peer_word(32'h4646CEBC, 4'h1, acc);
    chk("standby cleared", 32'h0, {31'h0, standby_heard});
  endtask : t_rx
  task automatic t_standby();
    @(posedge clk);
    tx_cmd <= CMD_STANDBY;
    for (int i = 0; i < 4; i++) begin
      tick(1);
      chk("standby word", 32'h7E7ECEFC, tx_word);
    end
    tick(1);
    chk("driver off", 32'h0, {31'h0, driver_on});
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status off", 32'h00000094, r);
    @(posedge clk);
    tx_cmd <= CMD_DATA;
    tick(1);
    chk("driver on", 32'h1, {31'h0, driver_on});
  endtask : t_standby
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_init(3'h5);
    t_init(3'h2);
    t_data();
    t_lost();
    t_rx();
    t_standby();
    results();
  end
  // The sequence needs under a thousand cycles; this allows four
  initial begin
    #20000;
    num_errors++;
    results();
  end
endmodule : lane_control_word_codec_bench
